// File: core/shared_select_pkg.sv
package shared_select_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [5:0] CTRL_OFFSET = 6'h00;
  localparam logic [5:0] IRQ_STATUS_OFFSET = 6'h04;
  localparam logic [5:0] IRQ_MASK_OFFSET = 6'h08;
  localparam logic [5:0] SHARED_BASE_OFFSET = 6'h20;
  // ****************************************
  // control register fields
  // ****************************************
  localparam int LOW_POWER_BIT = 7;
  localparam int LOW_VOLTAGE_BIT = 6;
  localparam int SELECT_BIT = 4;
  localparam int WATCHDOG_BIT = 0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h91;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ****************************************
  // interrupt status fields
  // ****************************************
  localparam int IRQ_WIDTH = 2;
  localparam int IRQ_LV_FALL_BIT = 0;
  localparam int IRQ_LV_RISE_BIT = 1;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 2'h0;
  // ****************************************
  // overlaid register bank
  // ****************************************
  localparam int SHARED_COUNT = 7;
  localparam logic [7:0] SHARED_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

// File: core/reset_sync.sv
module reset_sync
  import shared_select_pkg::*;
(
  // clock and raw reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // synchronised reset
  output logic o_nrst
);
  logic stage1;
  logic stage2;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end
    else
    begin
      stage1 <= 1'b1;
      stage2 <= stage1;
    end
  end
  assign o_nrst = stage2;
endmodule

// File: core/shared_bank.sv
module shared_bank
  import shared_select_pkg::*;
#(
  parameter int COUNT = SHARED_COUNT
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // access port
  input wire logic i_sel,
  input wire logic [$clog2(COUNT)-1:0] i_index,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  // read data
  output logic [7:0] o_rdata
);
  logic [7:0] legacy_reg [COUNT];
  logic [7:0] alt_reg [COUNT];
  // ****************************************
  // two physical registers per overlaid address
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < COUNT; g++)
    begin : gen_pair
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          legacy_reg[g] <= SHARED_RESET;
          alt_reg[g] <= SHARED_RESET;
        end
        else if (i_write && i_index == g)
        begin
          if (i_sel)
          begin
            alt_reg[g] <= i_wdata;
          end
          else
          begin
            legacy_reg[g] <= i_wdata;
          end
        end
      end
    end
  endgenerate
  // select alone steers the read
  assign o_rdata = i_sel ? alt_reg[i_index] : legacy_reg[i_index];
endmodule

// File: core/shared_select_ctrl.sv
// Operation
// - select bit routes overlaid addresses to alternate
// - bit 6 reads live core supply flag
// - bits 5 and 3..1 read zero
// - bit 7 low-power enable, r/w, reset zero
// - bit 0 watchdog enable, r/w, reset zero
// - overlaid addresses decoded by select bit only
// - select bit changes only on software write or reset
//
// The Avalon-MM slave port and the address map were left to the implementer.
module shared_select_ctrl
  import shared_select_pkg::*;
#(
  parameter int COUNT = SHARED_COUNT
)
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // avalon-mm slave
  input wire logic [5:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [31:0] I_WRITEDATA,
  input wire logic [3:0] I_BYTEENABLE,
  output logic [31:0] O_READDATA,
  output logic O_WAITREQUEST,
  // core supply comparator
  input wire logic I_CORE_SUPPLY_OK,
  // control outputs
  output logic O_REGULATOR_LOW_POWER_ENABLE,
  output logic O_SOFT_WATCHDOG_ENABLE,
  output logic O_SHARED_ADDRESS_SELECT,
  // interrupt
  output logic O_IRQ
);
  logic nrst;
  logic ack;
  logic regulator_low_power_enable;
  logic shared_address_select;
  logic soft_watchdog_enable;
  logic supply_prev;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [IRQ_WIDTH-1:0] irq_event;
  logic [7:0] ctrl_value;
  logic [7:0] bank_rdata;
  logic [5:0] bank_offset;
  logic bank_hit;
  logic [$clog2(COUNT)-1:0] bank_index;
  logic access;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic [31:0] next_readdata;
  // ****************************************
  // reset release
  // ****************************************
  reset_sync u_reset_sync
  (
    .i_clk(I_CORE_CLK),
    .i_nrst(I_NRST),
    .o_nrst(nrst)
  );
  // ****************************************
  // bus decode
  // ****************************************
  assign access = (I_READ || I_WRITE) && !ack;
  assign bank_offset = I_ADDRESS - SHARED_BASE_OFFSET;
  assign bank_hit = (I_ADDRESS >= SHARED_BASE_OFFSET) && (I_ADDRESS[1:0] == 2'h0)
    && (bank_offset[5:2] < 4'(COUNT));
  assign bank_index = bank_offset[$clog2(COUNT)+1:2];
  assign wr_ctrl = access && I_WRITE && I_BYTEENABLE[0] && I_ADDRESS == CTRL_OFFSET;
  assign wr_status = access && I_WRITE && I_BYTEENABLE[0] && I_ADDRESS == IRQ_STATUS_OFFSET;
  assign wr_mask = access && I_WRITE && I_BYTEENABLE[0] && I_ADDRESS == IRQ_MASK_OFFSET;
  // one wait cycle, then the answer
  assign O_WAITREQUEST = (I_READ || I_WRITE) && !ack;
  always_ff @(posedge I_CORE_CLK or negedge nrst)
  begin
    if (!nrst)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= access;
    end
  end
  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge I_CORE_CLK or negedge nrst)
  begin
    if (!nrst)
    begin
      regulator_low_power_enable <= CTRL_RESET[LOW_POWER_BIT];
      shared_address_select <= CTRL_RESET[SELECT_BIT];
      soft_watchdog_enable <= CTRL_RESET[WATCHDOG_BIT];
    end
    else if (wr_ctrl)
    begin
      // only writable bits are stored; others are discarded
      regulator_low_power_enable <= I_WRITEDATA[LOW_POWER_BIT];
      shared_address_select <= I_WRITEDATA[SELECT_BIT];
      soft_watchdog_enable <= I_WRITEDATA[WATCHDOG_BIT];
    end
  end
  always_comb
  begin
    ctrl_value = 8'h00;
    ctrl_value[LOW_POWER_BIT] = regulator_low_power_enable;
    ctrl_value[LOW_VOLTAGE_BIT] = I_CORE_SUPPLY_OK;
    ctrl_value[SELECT_BIT] = shared_address_select;
    ctrl_value[WATCHDOG_BIT] = soft_watchdog_enable;
  end
  // ****************************************
  // overlaid registers
  // ****************************************
  shared_bank #(
    .COUNT(COUNT)
  ) u_shared_bank
  (
    .i_clk(I_CORE_CLK),
    .i_nrst(nrst),
    .i_sel(shared_address_select),
    .i_index(bank_index),
    .i_write(access && I_WRITE && I_BYTEENABLE[0] && bank_hit),
    .i_wdata(I_WRITEDATA[7:0]),
    .o_rdata(bank_rdata)
  );
  // ****************************************
  // interrupts
  // ****************************************
  always_ff @(posedge I_CORE_CLK or negedge nrst)
  begin
    if (!nrst)
    begin
      supply_prev <= 1'b1;
    end
    else
    begin
      supply_prev <= I_CORE_SUPPLY_OK;
    end
  end
  always_comb
  begin
    irq_event = '0;
    irq_event[IRQ_LV_FALL_BIT] = supply_prev && !I_CORE_SUPPLY_OK;
    irq_event[IRQ_LV_RISE_BIT] = !supply_prev && I_CORE_SUPPLY_OK;
  end
  always_ff @(posedge I_CORE_CLK or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_status <= IRQ_RESET;
    end
    else if (wr_status)
    begin
      irq_status <= (irq_status & ~I_WRITEDATA[IRQ_WIDTH-1:0]) | irq_event;
    end
    else
    begin
      irq_status <= irq_status | irq_event;
    end
  end
  always_ff @(posedge I_CORE_CLK or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_mask <= IRQ_RESET;
    end
    else if (wr_mask)
    begin
      irq_mask <= I_WRITEDATA[IRQ_WIDTH-1:0];
    end
  end
  assign O_IRQ = |(irq_status & irq_mask);
  // ****************************************
  // read data
  // ****************************************
  always_comb
  begin
    next_readdata = UNMAPPED_READ;
    if (I_ADDRESS == CTRL_OFFSET)
    begin
      next_readdata = {24'h000000, ctrl_value};
    end
    else if (I_ADDRESS == IRQ_STATUS_OFFSET)
    begin
      next_readdata = {{(32-IRQ_WIDTH){1'b0}}, irq_status};
    end
    else if (I_ADDRESS == IRQ_MASK_OFFSET)
    begin
      next_readdata = {{(32-IRQ_WIDTH){1'b0}}, irq_mask};
    end
    else if (bank_hit)
    begin
      next_readdata = {24'h000000, bank_rdata};
    end
  end
  always_ff @(posedge I_CORE_CLK or negedge nrst)
  begin
    if (!nrst)
    begin
      O_READDATA <= 32'h00000000;
    end
    else if (access && I_READ)
    begin
      O_READDATA <= next_readdata;
    end
  end
  // ****************************************
  // control outputs
  // ****************************************
  assign O_REGULATOR_LOW_POWER_ENABLE = regulator_low_power_enable;
  assign O_SOFT_WATCHDOG_ENABLE = soft_watchdog_enable;
  assign O_SHARED_ADDRESS_SELECT = shared_address_select;
endmodule

// File: verification/shared_select_ctrl_props.sv
module shared_select_ctrl_props
  import shared_select_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // bus
  input wire logic [5:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [31:0] I_WRITEDATA,
  input wire logic [3:0] I_BYTEENABLE,
  input wire logic [31:0] O_READDATA,
  input wire logic O_WAITREQUEST,
  // device side
  input wire logic I_CORE_SUPPLY_OK,
  input wire logic O_REGULATOR_LOW_POWER_ENABLE,
  input wire logic O_SOFT_WATCHDOG_ENABLE,
  input wire logic O_SHARED_ADDRESS_SELECT,
  input wire logic O_IRQ
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  wire ctl = I_ADDRESS == CTRL_OFFSET && I_BYTEENABLE[0];
  sequence s_wait;
    O_WAITREQUEST ##1 !O_WAITREQUEST;
  endsequence
  sequence s_ctl_wr;
    I_WRITE && !O_WAITREQUEST && ctl;
  endsequence
  sequence s_rd_done;
    I_READ && !O_WAITREQUEST;
  endsequence
  a_wait_one_cycle: assert property ($rose(I_READ || I_WRITE) |-> s_wait)
    else $error("waitrequest not one cycle");
  a_idle_no_wait: assert property (!(I_READ || I_WRITE) |-> !O_WAITREQUEST)
    else $error("waitrequest while idle");
  a_low_power_write: assert property (s_ctl_wr
    |-> O_REGULATOR_LOW_POWER_ENABLE == I_WRITEDATA[LOW_POWER_BIT])
    else $error("low power bit not written");
  a_watchdog_write: assert property (s_ctl_wr
    |-> O_SOFT_WATCHDOG_ENABLE == I_WRITEDATA[WATCHDOG_BIT])
    else $error("watchdog bit not written");
  a_select_write: assert property (s_ctl_wr
    |-> O_SHARED_ADDRESS_SELECT == I_WRITEDATA[SELECT_BIT])
    else $error("select bit not written");
  a_select_holds: assert property (!(I_WRITE && ctl)
    |=> $stable(O_SHARED_ADDRESS_SELECT))
    else $error("select bit changed without write");
  a_ctrl_readback: assert property (s_rd_done ##0 I_ADDRESS == CTRL_OFFSET
    |-> O_READDATA == {24'h000000, O_REGULATOR_LOW_POWER_ENABLE, $past(I_CORE_SUPPLY_OK),
    1'h0, O_SHARED_ADDRESS_SELECT, 3'h0, O_SOFT_WATCHDOG_ENABLE})
    else $error("control read wrong");
  a_unmapped_zero: assert property (s_rd_done ##0 I_ADDRESS == 6'h3c
    |-> O_READDATA == UNMAPPED_READ)
    else $error("unmapped read not zero");
endmodule

// File: verification/shared_select_ctrl_tb.sv
module shared_select_ctrl_tb
  import shared_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic supply = 1'h1;
  logic [31:0] rdata;
  logic [31:0] got;
  logic wait_req, lp, wdt, sel, irq;
  int mismatches = 0;
  int n_tests = 0;
  initial
  begin
    forever #4 clk = ~clk;
  end
  shared_select_ctrl dut
  (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_ADDRESS(addr), .I_READ(rd), .I_WRITE(wr),
    .I_WRITEDATA(wdata), .I_BYTEENABLE(be), .O_READDATA(rdata), .O_WAITREQUEST(wait_req),
    .I_CORE_SUPPLY_OK(supply), .O_REGULATOR_LOW_POWER_ENABLE(lp),
    .O_SOFT_WATCHDOG_ENABLE(wdt), .O_SHARED_ADDRESS_SELECT(sel), .O_IRQ(irq)
  );
  // ****************************************
  // bus access and compare
  // ****************************************
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= {24'h000000, d};
    wr <= w;
    rd <= !w;
    do @(posedge clk);
    while (wait_req !== 1'h0);
    got = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: pin %b want %b", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    acc(1'h1, a, d);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    acc(1'h0, a, 8'h00);
    chk(got, e);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    rd_chk(CTRL_OFFSET, 32'h40);
    supply <= 1'h0;
    rd_chk(CTRL_OFFSET, 32'h00);
    $display("test reset done");
    wr_reg(CTRL_OFFSET, 8'hff);
    rd_chk(CTRL_OFFSET, 32'h91);
    chk_pin(lp, 1'h1);
    chk_pin(wdt, 1'h1);
    chk_pin(sel, 1'h1);
    be <= 4'he;
    wr_reg(CTRL_OFFSET, 8'h00);
    be <= 4'hf;
    rd_chk(CTRL_OFFSET, 32'h91);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    chk_pin(lp, 1'h0);
    chk_pin(wdt, 1'h0);
    chk_pin(sel, 1'h0);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    rd_chk(CTRL_OFFSET, 32'h00);
    wr_reg(CTRL_OFFSET, 8'h6e);
    rd_chk(CTRL_OFFSET, 32'h00);
    $display("test control done");
    for (int s = 0; s < 2; s++)
    begin
      wr_reg(CTRL_OFFSET, s ? 8'h10 : 8'h00);
      for (int i = 0; i < SHARED_COUNT; i++)
        wr_reg(SHARED_BASE_OFFSET + 6'(4 * i), {s[0], 3'h0, 4'(i + 1)});
    end
    for (int s = 1; s >= 0; s--)
    begin
      wr_reg(CTRL_OFFSET, s ? 8'h10 : 8'h00);
      for (int i = 0; i < SHARED_COUNT; i++)
        rd_chk(SHARED_BASE_OFFSET + 6'(4 * i), {24'h0, s[0], 3'h0, 4'(i + 1)});
      chk_pin(sel, s[0]);
    end
    wr_reg(6'h3c, 8'h5a);
    rd_chk(6'h3c, 32'h0);
    $display("test overlay done");
    rd_chk(IRQ_STATUS_OFFSET, 32'h1);
    chk_pin(irq, 1'h0);
    wr_reg(IRQ_MASK_OFFSET, 8'h03);
    chk_pin(irq, 1'h1);
    wr_reg(IRQ_STATUS_OFFSET, 8'h01);
    chk_pin(irq, 1'h0);
    supply <= 1'h1;
    rd_chk(CTRL_OFFSET, 32'h40);
    rd_chk(IRQ_STATUS_OFFSET, 32'h2);
    chk_pin(irq, 1'h1);
    wr_reg(IRQ_MASK_OFFSET, 8'h00);
    chk_pin(irq, 1'h0);
    $display("test interrupt done");
    test_done;
  end
  initial
  begin
    #20000;
    mismatches++;
    test_done;
  end
endmodule
bind shared_select_ctrl shared_select_ctrl_props u_props (.*);
